//--- logic/jcpa_arbiter.sv
/*
 jtag configuration port arbiter: shares one 16-bit configuration register
 port between a fabric requester and a 32-bit jtag scan register.
 assumes the tap controller state decode (capture, shift, update)
 and the instruction select arrive as pins in the tck domain; a tck edge
 is found by sampling on sys_clk, so tck must be well under sys_clk/4.
 the configuration register port is a one-cycle request, one-cycle done
 memory style port on sys_clk; port_clock activity is sensed as a pin.
*/
// Implementation choices: the placing of the registers and strobed register access.
`timescale 1ns/10ps
`include "jcpa_regs.svh"

module jcpa_arbiter (
    input wire logic sys_clk, // block clock, 40 MHz
    input wire logic nrst, // asynchronous reset, active low
    input wire logic tck_pin, // jtag clock pin
    input wire logic tdi_pin, // jtag data in
    input wire logic ir_sel_pin, // monitor instruction is loaded
    input wire logic capture_dr_pin, // tap in capture-dr
    input wire logic shift_dr_pin, // tap in shift-dr
    input wire logic update_dr_pin, // tap in update-dr
    output logic tdo, // jtag data out
    input wire logic port_clock, // configuration port clock pin
    input wire logic configured, // device configuration done
    input wire logic [1:0] jtag_mode, // jtag access mode
    input wire logic fab_req, // fabric request strobe
    input wire logic fab_we, // fabric write
    input wire logic [9:0] fab_addr, // fabric address
    input wire logic [15:0] fab_wdata, // fabric write data
    output logic [15:0] fab_rdata, // fabric read data
    output logic port_done_strobe, // fabric access finished
    output logic fab_refused, // fabric access refused, lock high
    output logic jtag_txn_active, // jtag transaction busy
    output logic jtag_wrote_flag, // jtag modified port
    output logic jtag_owns_port, // fabric locked out
    output logic cfg_req, // configuration port request
    output jcpa_pkg::jcpa_req_s cfg_cmd, // configuration port command
    input wire logic cfg_done, // configuration port done
    input wire logic [15:0] cfg_rdata, // configuration port read data
    output logic aux_enable, // auxiliary inputs enabled
    output logic monitor_reset // monitor reset pulse
);

    localparam int SYNC_W = 10; // synchronised pin count

    // raw pins gathered for the synchroniser
    logic [SYNC_W-1:0] pins_raw;
    logic [SYNC_W-1:0] sync1_q; // first stage, read only by second
    logic [SYNC_W-1:0] sync2_q; // second stage
    logic tck_prev_q; // tck one sample ago
    logic tck_rise;
    logic tck_fall;
    logic s_tck, s_tdi, s_sel, s_cap, s_shift, s_upd, s_pclk, s_cfgd;
    logic [1:0] s_mode; // access mode after sync

    assign pins_raw = {jtag_mode, configured, port_clock, update_dr_pin, shift_dr_pin,
                       capture_dr_pin, ir_sel_pin, tdi_pin, tck_pin};

    // two-flop synchroniser for every pin
    genvar gi;
    generate
        for (gi = 0; gi < SYNC_W; gi++) begin : g_sync
            always_ff @(posedge sys_clk or negedge nrst) begin
                if (!nrst) begin
                    sync1_q[gi] <= 1'b0;
                    sync2_q[gi] <= 1'b0;
                end else begin
                    sync1_q[gi] <= pins_raw[gi];
                    sync2_q[gi] <= sync1_q[gi];
                end
            end
        end
    endgenerate

    assign {s_mode, s_cfgd, s_pclk, s_upd, s_shift, s_cap, s_sel, s_tdi, s_tck} = sync2_q;

    // tck edge detection on the synchronised copy
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            tck_prev_q <= 1'b0;
        end else begin
            tck_prev_q <= s_tck;
        end
    end

    assign tck_rise = s_tck & ~tck_prev_q;
    assign tck_fall = ~s_tck & tck_prev_q;

    // scan register and held port data
    logic [`JCPA_SCAN_LEN-1:0] scan_q; // 32-bit scan register
    logic [15:0] held_q; // last jtag port data for capture
    logic tdo_q;
    logic cmd_pend_q; // update seen, command waiting
    logic [`JCPA_SCAN_LEN-1:0] cmd_q; // command latched at update

    // command fields
    logic [3:0] cmd_op;
    logic [9:0] cmd_addr;
    logic [15:0] cmd_data;
    assign cmd_op = cmd_q[`JCPA_OP_MSB:`JCPA_OP_LSB];
    assign cmd_addr = cmd_q[`JCPA_ADDR_MSB:`JCPA_ADDR_LSB];
    assign cmd_data = cmd_q[`JCPA_DATA_MSB:`JCPA_DATA_LSB];

    // capture, shift and update on tck rising edges
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            scan_q <= '0;
        end else if (tck_rise && s_sel) begin // host selected us
            if (s_cap) begin
                scan_q <= {16'h0000, held_q}; // held data, upper zero
            end else if (s_shift) begin
                scan_q <= {s_tdi, scan_q[`JCPA_SCAN_LEN-1:1]}; // lsb out first
            end
        end
    end

    // tdo changes on the falling tck edge
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            tdo_q <= 1'b0;
        end else if (tck_fall && s_sel && s_shift) begin
            tdo_q <= scan_q[0];
        end
    end

    assign tdo = tdo_q;

    // arbiter state machine
    jcpa_pkg::jcpa_state_e state_q;
    logic fab_pend_q; // queued fabric request
    jcpa_pkg::jcpa_req_s fab_hold_q; // queued fabric command
    logic jtag_upd_evt; // update-dr seen
    logic jtag_allowed; // mode permits this opcode
    logic fab_ok; // fabric may use the port
    logic pclk_ready;

    assign jtag_upd_evt = tck_rise && s_sel && s_upd;

    // mode filter on jtag opcodes
    always_comb begin
        jtag_allowed = 1'b0;
        case (s_mode)
            `JCPA_MODE_FULL: jtag_allowed = (cmd_op == `JCPA_OP_READ) ||
                                            (cmd_op == `JCPA_OP_WRITE);
            `JCPA_MODE_READONLY: jtag_allowed = (cmd_op == `JCPA_OP_READ);
            default: jtag_allowed = 1'b0;
        endcase
    end

    // latch command at update-dr, mark busy
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            cmd_q <= '0;
            cmd_pend_q <= 1'b0;
        end else if (jtag_upd_evt) begin
            cmd_q <= scan_q;
            cmd_pend_q <= 1'b1;
        end else if (state_q == jcpa_pkg::JCPA_IDLE && (pclk_ready || !jtag_allowed)) begin
            cmd_pend_q <= 1'b0; // taken or dropped; waits while port not ready
        end
    end

    // busy spans pending and executing jtag transaction
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            jtag_txn_active <= 1'b0;
        end else if (jtag_upd_evt) begin
            jtag_txn_active <= 1'b1;
        end else if ((state_q == jcpa_pkg::JCPA_JWAIT && cfg_done) ||
                     (state_q == jcpa_pkg::JCPA_IDLE && cmd_pend_q && !jtag_allowed)) begin
            jtag_txn_active <= 1'b0;
        end
    end

    assign fab_ok = !jtag_owns_port;

    // queue one fabric request; refused while locked
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            fab_pend_q <= 1'b0;
            fab_hold_q <= '0;
        end else if (fab_req && fab_ok) begin // one outstanding
            fab_pend_q <= 1'b1;
            fab_hold_q <= '{we: fab_we, addr: fab_addr, wdata: fab_wdata};
        end else if (state_q == jcpa_pkg::JCPA_FAB) begin
            fab_pend_q <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            fab_refused <= 1'b0;
        end else begin
            fab_refused <= fab_req && !fab_ok;
        end
    end

    // one port transaction at a time; jtag first unless fabric running
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            state_q <= jcpa_pkg::JCPA_IDLE;
        end else begin
            case (state_q)
                jcpa_pkg::JCPA_IDLE: begin
                    if (cmd_pend_q && jtag_allowed && pclk_ready) begin
                        state_q <= jcpa_pkg::JCPA_JTAG;
                    end else if (fab_pend_q && !cmd_pend_q && !jtag_txn_active && fab_ok) begin
                        state_q <= jcpa_pkg::JCPA_FAB;
                    end
                end
                jcpa_pkg::JCPA_FAB: state_q <= jcpa_pkg::JCPA_FWAIT;
                jcpa_pkg::JCPA_FWAIT: begin
                    if (cfg_done) begin
                        state_q <= jcpa_pkg::JCPA_IDLE; // fabric done before jtag
                    end
                end
                jcpa_pkg::JCPA_JTAG: state_q <= jcpa_pkg::JCPA_JWAIT;
                jcpa_pkg::JCPA_JWAIT: begin
                    if (cfg_done) begin
                        state_q <= jcpa_pkg::JCPA_IDLE;
                    end
                end
                default: state_q <= jcpa_pkg::JCPA_IDLE;
            endcase
        end
    end

    // port request and command registers
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            cfg_req <= 1'b0;
            cfg_cmd <= '0;
        end else begin
            cfg_req <= 1'b0;
            if (state_q == jcpa_pkg::JCPA_IDLE && cmd_pend_q && jtag_allowed && pclk_ready) begin
                cfg_req <= 1'b1;
                cfg_cmd <= '{we: (cmd_op == `JCPA_OP_WRITE), addr: cmd_addr,
                             wdata: cmd_data};
            end else if (state_q == jcpa_pkg::JCPA_IDLE && fab_pend_q && !cmd_pend_q &&
                         !jtag_txn_active && fab_ok) begin
                cfg_req <= 1'b1;
                cfg_cmd <= fab_hold_q;
            end
        end
    end

    // held data: written value or fresh read result
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            held_q <= `JCPA_HELD_RST;
        end else if (state_q == jcpa_pkg::JCPA_JWAIT && cfg_done) begin
            held_q <= cfg_cmd.we ? cfg_cmd.wdata : cfg_rdata;
        end
    end

    // fabric answer and done strobe
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            port_done_strobe <= 1'b0;
            fab_rdata <= 16'h0000;
        end else begin
            port_done_strobe <= state_q == jcpa_pkg::JCPA_FWAIT && cfg_done;
            if (state_q == jcpa_pkg::JCPA_FWAIT && cfg_done) begin
                fab_rdata <= cfg_rdata;
            end
        end
    end

    logic jwrite_done;
    assign jwrite_done = state_q == jcpa_pkg::JCPA_JWAIT && cfg_done && cfg_cmd.we;

    // modified flag: set wins over fabric clear
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            jtag_wrote_flag <= 1'b0;
        end else if (jwrite_done) begin
            jtag_wrote_flag <= 1'b1;
        end else if (state_q == jcpa_pkg::JCPA_FAB) begin
            jtag_wrote_flag <= 1'b0;
        end
    end

    // port clock activity: edges restart the idle timer
    logic pclk_prev_q;
    logic [7:0] idle_cnt_q;
    logic [4:0] wake_cnt_q;
    logic pclk_edge;
    assign pclk_edge = s_pclk & ~pclk_prev_q;

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            pclk_prev_q <= 1'b0;
            idle_cnt_q <= 8'h00;
            wake_cnt_q <= 5'h00;
        end else begin
            pclk_prev_q <= s_pclk;
            if (pclk_edge) begin
                idle_cnt_q <= 8'h00;
                if (wake_cnt_q != `JCPA_WAKE_CYCLES) begin
                    wake_cnt_q <= wake_cnt_q + 5'h01;
                end
            end else if (idle_cnt_q != `JCPA_IDLE_CYCLES) begin
                idle_cnt_q <= idle_cnt_q + 8'h01;
            end else begin
                wake_cnt_q <= 5'h00; // clock lost, not ready again
            end
        end
    end

    assign pclk_ready = wake_cnt_q == `JCPA_WAKE_CYCLES;

    // lock by jtag write at 00h
    logic lock_q;
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            lock_q <= 1'b0;
        end else if (jwrite_done && cfg_cmd.addr == `JCPA_ADDR_LOCK) begin
            if (cfg_cmd.wdata == `JCPA_VAL_ONE) begin
                lock_q <= 1'b1;
            end else if (cfg_cmd.wdata == `JCPA_VAL_ZERO) begin
                lock_q <= 1'b0;
            end
        end
    end

    assign jtag_owns_port = lock_q || !pclk_ready;

    // aux enable before configuration, reset pulse at 03h
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            aux_enable <= 1'b0;
            monitor_reset <= 1'b0;
        end else begin
            monitor_reset <= jwrite_done && cfg_cmd.addr == `JCPA_ADDR_RESET;
            if (jwrite_done && !s_cfgd && cfg_cmd.addr == `JCPA_ADDR_AUX &&
                cfg_cmd.wdata == `JCPA_VAL_ONE) begin
                aux_enable <= 1'b1;
            end
        end
    end

endmodule : jcpa_arbiter

//--- logic/jcpa_pkg.sv
/*
 types for the jtag configuration port arbiter.
 assumes jcpa_regs.svh is on the include path.
*/
`include "jcpa_regs.svh"

package jcpa_pkg;

    // one access to the configuration register port
    typedef struct packed {
        logic we;
        logic [9:0] addr;
        logic [15:0] wdata;
    } jcpa_req_s;

    // tap signals after synchronisation
    typedef struct packed {
        logic tck;
        logic tdi;
        logic tms_unused;
        logic sel;
        logic capture;
        logic shift;
        logic update;
        logic tlr;
    } jcpa_tap_s;

    // arbiter states
    typedef enum logic [4:0] {
        JCPA_IDLE = 5'b00001,
        JCPA_FAB = 5'b00010,
        JCPA_JTAG = 5'b00100,
        JCPA_FWAIT = 5'b01000,
        JCPA_JWAIT = 5'b10000
    } jcpa_state_e;

endpackage : jcpa_pkg

//--- logic/jcpa_regs.svh
/*
 constants for the jtag configuration port arbiter: command field positions,
 opcodes, special addresses, timing counts.
 assumes inclusion by bare name from the package and the arbiter module.
*/
`ifndef JCPA_REGS_SVH
`define JCPA_REGS_SVH

// scan register and command fields
`define JCPA_SCAN_LEN 32
`define JCPA_DATA_MSB 15
`define JCPA_DATA_LSB 0
`define JCPA_ADDR_MSB 25
`define JCPA_ADDR_LSB 16
`define JCPA_OP_MSB 29
`define JCPA_OP_LSB 26

// operation codes
`define JCPA_OP_NOP 4'h0
`define JCPA_OP_READ 4'h1
`define JCPA_OP_WRITE 4'h2

// special addresses and values
`define JCPA_ADDR_LOCK 10'h000
`define JCPA_ADDR_AUX 10'h002
`define JCPA_ADDR_RESET 10'h003
`define JCPA_VAL_ONE 16'h0001
`define JCPA_VAL_ZERO 16'h0000

// reset values
`define JCPA_HELD_RST 16'h0000

// timing: bound for jtag write resolution and lock release, in port clocks
`define JCPA_RESOLVE_CYCLES 18
// port clocks the lock stays high after the port clock starts
`define JCPA_WAKE_CYCLES 5'd16
// port clock absence timeout, in sys_clk cycles
`define JCPA_IDLE_CYCLES 8'd64

// access modes
`define JCPA_MODE_FULL 2'h0
`define JCPA_MODE_READONLY 2'h1
`define JCPA_MODE_OFF 2'h2

`endif

//--- verification/jcpa_arbiter_assertions.sv
/*
 concurrent checks on the arbiter's ports, bound to every jcpa_arbiter.
 assumes one sys_clk domain and a free running port_clock after reset.
*/
`timescale 1ns/10ps
module jcpa_arbiter_checker (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic port_clock,
    input wire logic configured,
    input wire logic fab_req,
    input wire logic fab_refused,
    input wire logic port_done_strobe,
    input wire logic jtag_txn_active,
    input wire logic jtag_wrote_flag,
    input wire logic jtag_owns_port,
    input wire logic cfg_req,
    input wire jcpa_pkg::jcpa_req_s cfg_cmd,
    input wire logic cfg_done,
    input wire logic aux_enable,
    input wire logic monitor_reset
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!nrst);

    logic pc_q; // port clock sampled last cycle
    logic [4:0] pc_cnt_q; // port clock rises since reset, saturating
    logic out_q; // a port request waits for its done

    // count port clock rises to know when the port must be ready
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            pc_q <= 1'b0;
            pc_cnt_q <= 5'h00;
        end else begin
            pc_q <= port_clock;
            if (port_clock && !pc_q && pc_cnt_q != 5'h1F) begin
                pc_cnt_q <= pc_cnt_q + 5'h01;
            end
        end
    end

    // track the outstanding port request
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            out_q <= 1'b0;
        end else if (cfg_req) begin
            out_q <= 1'b1;
        end else if (cfg_done) begin
            out_q <= 1'b0;
        end
    end

    chk_one_grant: assert property (cfg_req |-> !out_q)
        else $error("port request while one is outstanding");
    chk_lock_refuse: assert property (fab_req && jtag_owns_port |=> fab_refused && !port_done_strobe)
        else $error("locked fabric request not refused");
    chk_done_cause: assert property (port_done_strobe |-> $past(cfg_done) ##1 !port_done_strobe)
        else $error("fabric done without port done");
    chk_wrote_cause: assert property ($rose(jtag_wrote_flag) |-> cfg_cmd.we && ($past(cfg_done) || $past(cfg_done, 2)))
        else $error("modified flag rose without a write");
    chk_busy_bound: assert property ($rose(jtag_txn_active) |-> ##[1:72] !jtag_txn_active)
        else $error("jtag transaction not resolved in time");
    chk_reset_pulse: assert property (monitor_reset |-> cfg_cmd.we && cfg_cmd.addr == 10'h003 ##1 !monitor_reset)
        else $error("monitor reset without write at 03h");
    chk_aux_cause: assert property ($rose(aux_enable) |-> !configured && cfg_cmd.addr == 10'h002 && cfg_cmd.wdata == 16'h0001)
        else $error("aux enable without preconfig write");
    chk_lock_cause: assert property ($rose(jtag_owns_port) && pc_cnt_q == 5'h1F |-> cfg_cmd.addr == 10'h000 && cfg_cmd.wdata == 16'h0001)
        else $error("lock rose without lock write");
    chk_unlock_cause: assert property ($fell(jtag_owns_port) && pc_cnt_q == 5'h1F |-> cfg_cmd.addr == 10'h000 && cfg_cmd.wdata == 16'h0000)
        else $error("lock fell without unlock write");
    chk_wake_lock: assert property (pc_cnt_q < 5'd15 |-> jtag_owns_port)
        else $error("lock low before port clock ready");
    chk_wake_free: assert property (pc_cnt_q == 5'd18 |-> !jtag_owns_port)
        else $error("lock still high after port clock start");
endmodule : jcpa_arbiter_checker

bind jcpa_arbiter jcpa_arbiter_checker u_chk (.sys_clk, .nrst, .port_clock, .configured,
    .fab_req, .fab_refused, .port_done_strobe, .jtag_txn_active, .jtag_wrote_flag,
    .jtag_owns_port, .cfg_req, .cfg_cmd, .cfg_done, .aux_enable, .monitor_reset);

//--- verification/jcpa_arbiter_tb.sv
/*
 self-checking bench: jtag host scans, fabric accesses, port model.
 assumes the checker and port model are compiled before it.
*/
`timescale 1ns/10ps
module jcpa_arbiter_tb;
    logic sys_clk = 1'b0; // 40 MHz
    logic nrst = 1'b0;
    logic tck_pin = 1'b0; // stands low outside scans
    logic tdi_pin = 1'b0;
    logic ir_sel_pin = 1'b0;
    logic capture_dr_pin = 1'b0;
    logic shift_dr_pin = 1'b0;
    logic update_dr_pin = 1'b0;
    logic port_clock = 1'b0; // 10 MHz, free running
    logic configured = 1'b0; // device starts unconfigured
    logic [1:0] jtag_mode = 2'h0;
    logic fab_req = 1'b0;
    logic fab_we = 1'b0;
    logic [9:0] fab_addr = 10'h000;
    logic [15:0] fab_wdata = 16'h0000;
    logic tdo, port_done_strobe, fab_refused, cfg_req, cfg_done, aux_enable, monitor_reset;
    logic jtag_txn_active, jtag_wrote_flag, jtag_owns_port;
    logic [15:0] fab_rdata, cfg_rdata;
    jcpa_pkg::jcpa_req_s cfg_cmd;
    int lat = 2; // port model answer delay
    int fail_count = 0;
    int num_checks = 0;
    logic saw_rst = 1'b0; // a monitor reset pulse was seen

    always #12.5 sys_clk = ~sys_clk;
    always #50 port_clock = ~port_clock;
    always @(posedge sys_clk) if (monitor_reset === 1'b1) saw_rst <= 1'b1;

    jcpa_arbiter uut (.sys_clk(sys_clk), .nrst(nrst), .tck_pin(tck_pin), .tdi_pin(tdi_pin),
        .ir_sel_pin(ir_sel_pin), .capture_dr_pin(capture_dr_pin), .shift_dr_pin(shift_dr_pin),
        .update_dr_pin(update_dr_pin), .tdo(tdo), .port_clock(port_clock),
        .configured(configured), .jtag_mode(jtag_mode), .fab_req(fab_req), .fab_we(fab_we),
        .fab_addr(fab_addr), .fab_wdata(fab_wdata), .fab_rdata(fab_rdata),
        .port_done_strobe(port_done_strobe), .fab_refused(fab_refused),
        .jtag_txn_active(jtag_txn_active), .jtag_wrote_flag(jtag_wrote_flag),
        .jtag_owns_port(jtag_owns_port), .cfg_req(cfg_req), .cfg_cmd(cfg_cmd),
        .cfg_done(cfg_done), .cfg_rdata(cfg_rdata), .aux_enable(aux_enable),
        .monitor_reset(monitor_reset));

    jcpa_port_model u_port (.sys_clk(sys_clk), .nrst(nrst), .cfg_req(cfg_req),
        .cfg_cmd(cfg_cmd), .lat(lat), .cfg_done(cfg_done), .cfg_rdata(cfg_rdata));

    task automatic cmp_bit(input string n, input logic e, input logic g);
        num_checks++;
        if (g !== e) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask : cmp_bit

    task automatic cmp_word(input string n, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask : cmp_word

    // one tck period; tdo is taken late in the high phase
    task automatic tk(input logic c, input logic s, input logic u, input logic d, output logic o);
        capture_dr_pin = c;
        shift_dr_pin = s;
        update_dr_pin = u;
        tdi_pin = d;
        #100 tck_pin = 1'b1;
        #99 o = tdo;
        #1 tck_pin = 1'b0;
    endtask : tk

    // one data register scan: capture, 32 shifts lsb first, exit, update, idle
    task automatic scan(input logic [3:0] op, input logic [9:0] a, input logic [15:0] d,
        input int rti, output logic [31:0] got);
        logic [31:0] cmd;
        logic o;
        cmd = {2'b00, op, a, d};
        @(posedge sys_clk);
        #3;
        tk(1'b1, 1'b0, 1'b0, 1'b0, o);
        for (int i = 0; i < 32; i++) begin
            tk(1'b0, 1'b1, 1'b0, cmd[i], o);
            got[i] = o;
        end
        tk(1'b0, 1'b0, 1'b0, 1'b0, o);
        tk(1'b0, 1'b0, 1'b1, 1'b0, o);
        repeat (rti) tk(1'b0, 1'b0, 1'b0, 1'b0, o);
    endtask : scan

    // one fabric access, waiting for done or refusal before returning
    task automatic fab(input logic we, input logic [9:0] a, input logic [15:0] d,
        output logic [15:0] q, output logic rf, output logic bz);
        @(posedge sys_clk);
        fab_req <= 1'b1;
        fab_we <= we;
        fab_addr <= a;
        fab_wdata <= d;
        @(posedge sys_clk);
        fab_req <= 1'b0;
        repeat (400) begin
            @(negedge sys_clk);
            if (port_done_strobe === 1'b1 || fab_refused === 1'b1) break;
        end
        q = fab_rdata;
        rf = fab_refused;
        bz = jtag_txn_active;
    endtask : fab

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : report_and_stop

    // the tests need about 150 us
    initial begin
        #800000;
        fail_count++;
        report_and_stop();
    end

    initial begin
        logic [31:0] g;
        logic [15:0] q;
        logic rf, bz;
        repeat (8) @(posedge sys_clk);
        nrst <= 1'b1;
        @(negedge sys_clk);
        cmp_bit("lock at wake", 1'b1, jtag_owns_port);
        fab(1'b1, 10'h005, 16'h1234, q, rf, bz);
        cmp_bit("refusal at wake", 1'b1, rf);
        repeat (80) @(negedge sys_clk);
        cmp_bit("lock after wake", 1'b0, jtag_owns_port);
        fab(1'b1, 10'h005, 16'h1234, q, rf, bz);
        fab(1'b0, 10'h005, 16'h0000, q, rf, bz);
        cmp_word("fabric read", 32'h1234, {16'h0, q});
        $display("test wake and fabric done");
        ir_sel_pin = 1'b1;
        scan(4'h2, 10'h007, 16'hBEEF, 10, g);
        cmp_bit("modified set", 1'b1, jtag_wrote_flag);
        fab(1'b0, 10'h007, 16'h0000, q, rf, bz);
        cmp_word("read of jtag write", 32'hBEEF, {16'h0, q});
        cmp_bit("modified cleared", 1'b0, jtag_wrote_flag);
        scan(4'h1, 10'h005, 16'h0000, 10, g);
        cmp_word("capture of written", 32'h0000BEEF, g);
        scan(4'h1, 10'h009, 16'h0000, 10, g);
        cmp_word("first read", 32'h00001234, g);
        scan(4'h0, 10'h000, 16'h0000, 10, g);
        cmp_word("pipelined read", 32'h00005A09, g);
        $display("test jtag write and read done");
        lat = 40;
        scan(4'h1, 10'h007, 16'h0000, 0, g);
        scan(4'h0, 10'h000, 16'h0000, 10, g);
        cmp_word("stale capture", 32'h00005A09, g);
        scan(4'h0, 10'h000, 16'h0000, 10, g);
        cmp_word("late capture", 32'h0000BEEF, g);
        $display("test stale read done");
        lat = 8;
        fork
            scan(4'h2, 10'h008, 16'h00AA, 10, g);
            begin
                wait (update_dr_pin === 1'b1);
                fab(1'b0, 10'h008, 16'h0000, q, rf, bz);
            end
        join
        cmp_word("fabric before jtag", 32'h5A08, {16'h0, q});
        cmp_bit("jtag after fabric", 1'b1, jtag_wrote_flag);
        fork
            scan(4'h2, 10'h008, 16'h00BB, 10, g);
            begin
                wait (jtag_txn_active === 1'b1);
                fab(1'b0, 10'h008, 16'h0000, q, rf, bz);
            end
        join
        cmp_bit("busy low at done", 1'b0, bz);
        cmp_word("queued read", 32'h00BB, {16'h0, q});
        $display("test contention done");
        lat = 2;
        scan(4'h2, 10'h000, 16'h0001, 10, g);
        cmp_bit("lock set", 1'b1, jtag_owns_port);
        fab(1'b0, 10'h005, 16'h0000, q, rf, bz);
        cmp_bit("locked refusal", 1'b1, rf);
        scan(4'h2, 10'h000, 16'h0000, 10, g);
        cmp_bit("lock clear", 1'b0, jtag_owns_port);
        fab(1'b0, 10'h005, 16'h0000, q, rf, bz);
        cmp_bit("unlocked access", 1'b0, rf);
        $display("test lock done");
        configured = 1'b1;
        scan(4'h2, 10'h002, 16'h0001, 10, g);
        cmp_bit("aux after config", 1'b0, aux_enable);
        configured = 1'b0;
        scan(4'h2, 10'h002, 16'h0001, 10, g);
        cmp_bit("aux enabled", 1'b1, aux_enable);
        cmp_bit("no reset yet", 1'b0, saw_rst);
        scan(4'h2, 10'h003, 16'hABCD, 10, g);
        cmp_bit("monitor reset", 1'b1, saw_rst);
        for (int m = 1; m < 3; m++) begin
            jtag_mode = 2'(m);
            scan(4'h2, 10'h005, 16'h0F0F, 10, g);
            jtag_mode = 2'h0;
            fab(1'b0, 10'h005, 16'h0000, q, rf, bz);
            cmp_word("mode blocks write", 32'h1234, {16'h0, q});
        end
        $display("test aux reset and modes done");
        report_and_stop();
    end
endmodule : jcpa_arbiter_tb

//--- verification/jcpa_port_model.sv
/*
 behavioural configuration register port: 1024 words, done after lat cycles.
 assumes one request at a time and lat of at least 1.
*/
`timescale 1ns/10ps
module jcpa_port_model (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic cfg_req,
    input wire jcpa_pkg::jcpa_req_s cfg_cmd,
    input wire integer lat,
    output logic cfg_done,
    output logic [15:0] cfg_rdata
);
    logic [15:0] mem [1024]; // register contents
    jcpa_pkg::jcpa_req_s cmd_q; // request being served
    int cnt_q; // cycles left to the answer

    // known start pattern so reads of untouched words are predictable
    initial begin
        for (int i = 0; i < 1024; i++) begin
            mem[i] = 16'h5A00 ^ 16'(i);
        end
    end

    // serve one request; read data toggle except in the done cycle of a read
    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            cnt_q <= 0;
            cfg_done <= 1'b0;
            cfg_rdata <= 16'hFFFF;
        end else begin
            cfg_done <= 1'b0;
            cfg_rdata <= ~cfg_rdata;
            if (cfg_req) begin
                cmd_q <= cfg_cmd;
                cnt_q <= lat;
            end else if (cnt_q == 1) begin
                cnt_q <= 0;
                cfg_done <= 1'b1;
                if (cmd_q.we) begin
                    mem[cmd_q.addr] <= cmd_q.wdata;
                end else begin
                    cfg_rdata <= mem[cmd_q.addr];
                end
            end else if (cnt_q > 1) begin
                cnt_q <= cnt_q - 1;
            end
        end
    end
endmodule : jcpa_port_model
